// ===== verilog/cgec_defs.svh
`ifndef CGEC_DEFS_SVH
`define CGEC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CGEC_OFF_EXT_CTRL   8'h00
`define CGEC_OFF_TRIM       8'h04
`define CGEC_OFF_CTRL_ONE   8'h08
`define CGEC_OFF_STATUS     8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CGEC_BUS_CLOCK_DIVIDER_HI        7
`define CGEC_BUS_CLOCK_DIVIDER_LO        6
`define CGEC_RANGE_BIT      5
`define CGEC_GAIN_BIT       4
`define CGEC_LP_BIT         3
`define CGEC_SRC_BIT        2
`define CGEC_EN_BIT         1
`define CGEC_KEEP_BIT       0
`define CGEC_SYSTEM_CLOCK_SELECT_HI        7
`define CGEC_SYSTEM_CLOCK_SELECT_LO        6
`define CGEC_REFINT_BIT     2
`define CGEC_FINE_BIT       0
`define CGEC_INITDONE_BIT   1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CGEC_EXT_CTRL_RST   8'h40
`define CGEC_TRIM_RST       8'h80
`define CGEC_SYSTEM_CLOCK_SELECT_RST       2'h0
`define CGEC_REFINT_RST     1'h1
`define CGEC_FINE_RST       1'h0
`define CGEC_OSC_INIT_CYC   10'h200

`endif

// ===== verilog/cgec_pkg.sv
package cgec_pkg;

  typedef struct packed {
    logic [7:0] ext_ctrl;
    logic [7:0] trim;
    logic [1:0] system_clock_select;
    logic       ref_int;
    logic       fine;
    logic [9:0] osc_cnt;
    logic       osc_done;
    logic       pre_stop_ext;
    logic [2:0] div_cnt;
    logic       bus_en;
    logic [1:0] sys_sel;
    logic       loop_pd;
    logic       ext_ref_en;
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_strb0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } cgec_state_t;

endpackage

// ===== verilog/cgec_top.sv
`timescale 1ns/1ps
`include "cgec_defs.svh"

module cgec_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        stop_mode,
  output      logic        bus_clk_en,
  output      logic [1:0]  sys_clk_select,
  output      logic        ext_ref_high_range,
  output      logic        oscillator_high_gain,
  output      logic        loop_power_down,
  output      logic        osc_request,
  output      logic        ext_ref_clock_out_en,
  output      logic [8:0]  int_ref_trim,
  output      logic        oscillator_init_done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cgec_pkg::cgec_state_t st_ff;
  cgec_pkg::cgec_state_t nxt_st;

  logic [1:0]  eff_system_clock_select;
  logic        ext_mode;
  logic        osc_active;
  logic [2:0]  div_load;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic [10:0] act_run_ff;
  logic [10:0] nxt_act_run;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    eff_system_clock_select   = (st_ff.system_clock_select == 2'h3) ? 2'h0 : st_ff.system_clock_select;
    ext_mode   = (eff_system_clock_select == 2'h2) || ((eff_system_clock_select == 2'h0) && !st_ff.ref_int);
    osc_active = st_ff.ext_ctrl[`CGEC_SRC_BIT] && (st_ff.ext_ctrl[`CGEC_EN_BIT] || ext_mode);
    case (st_ff.ext_ctrl[`CGEC_BUS_CLOCK_DIVIDER_HI:`CGEC_BUS_CLOCK_DIVIDER_LO])
      2'h0:    div_load = 3'h0;
      2'h1:    div_load = 3'h1;
      2'h2:    div_load = 3'h3;
      default: div_load = 3'h7;
    endcase
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      `CGEC_OFF_EXT_CTRL: rd_byte = st_ff.ext_ctrl;
      `CGEC_OFF_TRIM:     rd_byte = st_ff.trim;
      `CGEC_OFF_CTRL_ONE: rd_byte = {st_ff.system_clock_select, 3'h0, st_ff.ref_int, 2'h0};
      `CGEC_OFF_STATUS:   rd_byte = {6'h0, st_ff.osc_done, st_ff.fine};
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Address and data are captured independently, in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got   = 1'b1;
      nxt_st.w_data  = s_axi_wdata[7:0];
      nxt_st.w_strb0 = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = 2'h0;
      case ({st_ff.aw_addr[7:2], 2'h0})
        `CGEC_OFF_EXT_CTRL: begin
          if (st_ff.w_strb0) begin
            nxt_st.ext_ctrl = st_ff.w_data;
          end
        end
        `CGEC_OFF_TRIM: begin
          if (st_ff.w_strb0) begin
            nxt_st.trim = st_ff.w_data;
          end
        end
        `CGEC_OFF_CTRL_ONE: begin
          if (st_ff.w_strb0) begin
            nxt_st.system_clock_select    = st_ff.w_data[`CGEC_SYSTEM_CLOCK_SELECT_HI:`CGEC_SYSTEM_CLOCK_SELECT_LO];
            nxt_st.ref_int = st_ff.w_data[`CGEC_REFINT_BIT];
          end
        end
        `CGEC_OFF_STATUS: begin
          if (st_ff.w_strb0) begin
            nxt_st.fine = st_ff.w_data[`CGEC_FINE_BIT];
          end
        end
        default: nxt_st.bresp = 2'h2;
      endcase
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

    // Read data is sampled at the address handshake
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_byte;
      nxt_st.rresp  = rd_ok ? 2'h0 : 2'h2;
    end
    nxt_st.arready = !nxt_st.rvalid;

    // Bus clock enable: one pulse every 1, 2, 4 or 8 cycles
    nxt_st.bus_en  = (st_ff.div_cnt == 3'h0);
    nxt_st.div_cnt = (st_ff.div_cnt == 3'h0) ? div_load : st_ff.div_cnt - 3'h1;

    nxt_st.sys_sel = eff_system_clock_select;
    nxt_st.loop_pd = st_ff.ext_ctrl[`CGEC_LP_BIT] && (eff_system_clock_select != 2'h0);

    // Mode is frozen on stop entry so the keep decision sees the prior mode
    if (!stop_mode) begin
      nxt_st.pre_stop_ext = ext_mode;
    end
    if (stop_mode) begin
      nxt_st.ext_ref_en = st_ff.ext_ctrl[`CGEC_KEEP_BIT] &&
                          (st_ff.ext_ctrl[`CGEC_EN_BIT] || st_ff.pre_stop_ext);
    end else begin
      nxt_st.ext_ref_en = st_ff.ext_ctrl[`CGEC_EN_BIT];
    end

    // Oscillator start-up count; ready holds until its clear terms
    if (!st_ff.ext_ctrl[`CGEC_SRC_BIT] || (!ext_mode && !st_ff.ext_ctrl[`CGEC_EN_BIT])) begin
      nxt_st.osc_cnt  = 10'h000;
      nxt_st.osc_done = 1'b0;
    end else if (osc_active && !st_ff.osc_done) begin
      if (st_ff.osc_cnt == `CGEC_OSC_INIT_CYC - 10'h001) begin
        nxt_st.osc_done = 1'b1;
      end else begin
        nxt_st.osc_cnt = st_ff.osc_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff              <= '0;
      st_ff.ext_ctrl     <= `CGEC_EXT_CTRL_RST;
      st_ff.trim         <= `CGEC_TRIM_RST;
      st_ff.system_clock_select         <= `CGEC_SYSTEM_CLOCK_SELECT_RST;
      st_ff.ref_int      <= `CGEC_REFINT_RST;
      st_ff.fine         <= `CGEC_FINE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready        = st_ff.awready;
  assign s_axi_wready         = st_ff.wready;
  assign s_axi_bvalid         = st_ff.bvalid;
  assign s_axi_bresp          = st_ff.bresp;
  assign s_axi_arready        = st_ff.arready;
  assign s_axi_rvalid         = st_ff.rvalid;
  assign s_axi_rdata          = {24'h000000, st_ff.rdata};
  assign s_axi_rresp          = st_ff.rresp;
  assign bus_clk_en           = st_ff.bus_en;
  assign sys_clk_select       = st_ff.sys_sel;
  assign ext_ref_high_range   = st_ff.ext_ctrl[`CGEC_RANGE_BIT];
  assign oscillator_high_gain = st_ff.ext_ctrl[`CGEC_GAIN_BIT];
  assign loop_power_down      = st_ff.loop_pd;
  assign osc_request          = st_ff.ext_ctrl[`CGEC_SRC_BIT];
  assign ext_ref_clock_out_en = st_ff.ext_ref_en;
  // Fine bit sits below the main field, so the code stays binary weighted
  assign int_ref_trim         = {st_ff.trim, st_ff.fine};
  assign oscillator_init_done = st_ff.osc_done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper: cycles the oscillator has been continuously in use
  always_comb begin
    nxt_act_run = act_run_ff;
    if (!osc_active) begin
      nxt_act_run = 11'h000;
    end else if (act_run_ff != 11'h7ff) begin
      nxt_act_run = act_run_ff + 11'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_run_ff <= 11'h000;
    end else begin
      act_run_ff <= nxt_act_run;
    end
  end

  property p_bus_clock_divider_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> st_ff.ext_ctrl[`CGEC_BUS_CLOCK_DIVIDER_HI:`CGEC_BUS_CLOCK_DIVIDER_LO] == 2'h1;
  endproperty
  a_bus_clock_divider_reset: assert property (p_bus_clock_divider_reset) else $error("Bus divider not 01 after reset");

  property p_div_four;
    @(posedge aclk) disable iff (!aresetn)
      ($past(st_ff.ext_ctrl[7:6]) == 2'h2 && st_ff.ext_ctrl[7:6] == 2'h2 && bus_clk_en)
        ##1 (st_ff.ext_ctrl[7:6] == 2'h2 && !bus_clk_en) [*3] |=> bus_clk_en;
  endproperty
  a_div_four: assert property (p_div_four) else $error("Divide by four pulse spacing wrong");

  property p_div_eight_gap;
    @(posedge aclk) disable iff (!aresetn)
      ($past(st_ff.ext_ctrl[7:6]) == 2'h3 && st_ff.ext_ctrl[7:6] == 2'h3 && bus_clk_en)
        ##1 (st_ff.ext_ctrl[7:6] == 2'h3) [*6] |-> !bus_clk_en;
  endproperty
  a_div_eight_gap: assert property (p_div_eight_gap) else $error("Divide by eight pulsed early");

  property p_loop_down;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff.ext_ctrl[`CGEC_LP_BIT] && st_ff.system_clock_select == 2'h1) |=> loop_power_down;
  endproperty
  a_loop_down: assert property (p_loop_down) else $error("Loop not powered down in bypass");

  property p_loop_run;
    @(posedge aclk) disable iff (!aresetn)
      (!st_ff.ext_ctrl[`CGEC_LP_BIT] || st_ff.system_clock_select == 2'h3) |=> !loop_power_down;
  endproperty
  a_loop_run: assert property (p_loop_run) else $error("Loop powered down wrongly");

  property p_reserved_sel;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.system_clock_select == 2'h3 |=> sys_clk_select == 2'h0;
  endproperty
  a_reserved_sel: assert property (p_reserved_sel) else $error("Reserved select not treated as 00");

  property p_stop_gate;
    @(posedge aclk) disable iff (!aresetn)
      (stop_mode && !st_ff.ext_ctrl[`CGEC_KEEP_BIT]) |=> !ext_ref_clock_out_en;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("Reference not gated in stop");

  property p_run_enable;
    @(posedge aclk) disable iff (!aresetn)
      (!stop_mode && st_ff.ext_ctrl[`CGEC_EN_BIT]) |=> ext_ref_clock_out_en;
  endproperty
  a_run_enable: assert property (p_run_enable) else $error("Reference output not active");

  property p_osc_clear;
    @(posedge aclk) disable iff (!aresetn)
      !st_ff.ext_ctrl[`CGEC_SRC_BIT] |=> !oscillator_init_done;
  endproperty
  a_osc_clear: assert property (p_osc_clear) else $error("Oscillator ready without request");

  property p_osc_set;
    @(posedge aclk) disable iff (!aresetn)
      act_run_ff > 11'h200 |-> oscillator_init_done;
  endproperty
  a_osc_set: assert property (p_osc_set) else $error("Oscillator ready late");

  property p_osc_early;
    @(posedge aclk) disable iff (!aresetn)
      $rose(oscillator_init_done) |-> act_run_ff == 11'h200;
  endproperty
  a_osc_early: assert property (p_osc_early) else $error("Oscillator ready at wrong cycle");

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("Write response dropped");

  property p_readback;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h01) |=>
        s_axi_rvalid && s_axi_rdata[7:0] == $past(st_ff.trim);
  endproperty
  a_readback: assert property (p_readback) else $error("Trim read mismatch");

  property p_div_one;
    @(posedge aclk) disable iff (!aresetn)
      ($past(st_ff.ext_ctrl[7:6]) == 2'h0 && bus_clk_en) |=> bus_clk_en;
  endproperty
  a_div_one: assert property (p_div_one) else $error("Divide by one missed a pulse");

  // Reset divide by two: pulse, gap, pulse
  property p_div_two;
    @(posedge aclk) disable iff (!aresetn)
      ($past(st_ff.ext_ctrl[7:6]) == 2'h1 && bus_clk_en) |=> !bus_clk_en ##1 bus_clk_en;
  endproperty
  a_div_two: assert property (p_div_two) else $error("Divide by two pulse spacing wrong");

  property p_stop_keep;
    @(posedge aclk) disable iff (!aresetn)
      (stop_mode && st_ff.ext_ctrl[`CGEC_KEEP_BIT] && st_ff.ext_ctrl[`CGEC_EN_BIT]) |=> ext_ref_clock_out_en;
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("Reference not kept in stop");

  property p_run_disable;
    @(posedge aclk) disable iff (!aresetn)
      (!stop_mode && !st_ff.ext_ctrl[`CGEC_EN_BIT]) |=> !ext_ref_clock_out_en;
  endproperty
  a_run_disable: assert property (p_run_disable) else $error("Reference output active while disabled");

  // Ready is sticky while the oscillator stays in use
  property p_osc_hold;
    @(posedge aclk) disable iff (!aresetn)
      (oscillator_init_done && osc_active) |=> oscillator_init_done;
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("Oscillator ready dropped while in use");

  property p_slverr;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff.aw_got && st_ff.w_got && st_ff.aw_addr[7:4] != 4'h0) |=> s_axi_bvalid && s_axi_bresp == 2'h2;
  endproperty
  a_slverr: assert property (p_slverr) else $error("Unmapped write not refused");

endmodule

// ===== sim/cgec_xosc_model.sv
`timescale 1ns/1ps

module cgec_xosc_model #(
  parameter int HALF_HI = 3,
  parameter int HALF_LO = 40
) (
  input  wire logic osc_request,
  input  wire logic ext_ref_high_range,
  input  wire logic oscillator_high_gain,
  output      logic osc_clk
);
  // ----------------------------------------
  // Crystal output
  // ----------------------------------------
  // Gain only shapes the amplitude of a real crystal, so it is not modelled
  // Forced low at the end of the half period under way when the request drops, then still until requested again
  initial osc_clk = 1'b0;
  always begin
    if (osc_request === 1'b1) begin
      #((ext_ref_high_range === 1'b1) ? HALF_HI : HALF_LO);
      osc_clk = ~osc_clk;
    end else begin
      osc_clk = 1'b0;
      @(osc_request);
    end
  end
endmodule

// ===== sim/cgec_top_tb.sv
`timescale 1ns/1ps

module cgec_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        stop_mode = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sys_clk_select;
  logic [31:0] s_axi_rdata;
  logic        bus_clk_en, ext_ref_high_range, oscillator_high_gain, loop_power_down;
  logic        osc_request, ext_ref_clock_out_en, oscillator_init_done, osc_clk;
  logic [8:0]  int_ref_trim;
  logic [1:0]  wresp;
  int          n_errors = 0;
  int          checked = 0;
  logic [7:0]  fv [2] = '{8'h36, 8'hc9};
  logic [7:0]  st_c1 [4] = '{8'h04, 8'h04, 8'h04, 8'h80};
  logic [7:0]  st_ex [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
  logic        st_q [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  always #2.5 aclk = ~aclk;

  cgec_top cgec_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .stop_mode, .bus_clk_en, .sys_clk_select, .ext_ref_high_range, .oscillator_high_gain,
    .loop_power_down, .osc_request, .ext_ref_clock_out_en, .int_ref_trim, .oscillator_init_done
  );

  cgec_xosc_model cgec_xosc_model_inst (
    .osc_request, .ext_ref_high_range, .oscillator_high_gain, .osc_clk
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic r8(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask

  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, 4'hf, wresp);
    chk({30'h0, wresp}, 32'h0);
  endtask

  // Counting over 64 cycles makes the figure independent of the pulse phase
  task automatic pulses(input int d);
    logic [31:0] n;
    n = 32'h0;
    cyc(8);
    repeat (64) begin
      @(posedge aclk);
      if (bus_clk_en === 1'b1) n++;
    end
    chk(n, 32'd64 >> d);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #100000;
    n_errors++;
    test_done();
  end

  initial begin
    cyc(12);
    aresetn <= 1'b1;
    cyc(3);
    chk({30'h0, sys_clk_select}, 32'h0);
    chk({23'h0, int_ref_trim}, 32'h100);
    r8(8'h00, 32'h40, 2'h0);
    r8(8'h04, 32'h80, 2'h0);
    pulses(1);
    $display("test reset done");
    for (int d = 0; d < 4; d++) begin
      w8(8'h00, 8'(d << 6));
      pulses(d);
    end
    $display("test divider done");
    foreach (fv[i]) begin
      w8(8'h00, fv[i]);
      r8(8'h00, {24'h0, fv[i]}, 2'h0);
      w8(8'h04, fv[i]);
      w8(8'h0c, {7'h0, fv[i][0]});
      cyc(3);
      chk1(ext_ref_high_range, fv[i][5]);
      chk1(oscillator_high_gain, fv[i][4]);
      chk1(osc_request, fv[i][2]);
      chk1(osc_clk && !fv[i][2], 1'b0);
      chk1(ext_ref_clock_out_en, fv[i][1]);
      chk({23'h0, int_ref_trim}, {23'h0, fv[i], fv[i][0]});
      r8(8'h04, {24'h0, fv[i]}, 2'h0);
    end
    $display("test fields done");
    for (int lp = 0; lp < 2; lp++) begin
      for (int s = 0; s < 4; s++) begin
        w8(8'h00, 8'(lp << 3));
        w8(8'h08, 8'((s << 6) | 4));
        cyc(3);
        chk1(loop_power_down, 1'(lp == 1 && (s == 1 || s == 2)));
        chk({30'h0, sys_clk_select}, (s == 3) ? 32'h0 : 32'(s));
      end
    end
    $display("test modes done");
    foreach (st_ex[i]) begin
      w8(8'h08, st_c1[i]);
      w8(8'h00, st_ex[i]);
      cyc(3);
      chk1(ext_ref_clock_out_en, st_ex[i][1]);
      stop_mode <= 1'b1;
      cyc(3);
      chk1(ext_ref_clock_out_en, st_q[i]);
      stop_mode <= 1'b0;
    end
    $display("test stop done");
    w8(8'h08, 8'h04);
    w8(8'h00, 8'h06);
    cyc(500);
    chk1(oscillator_init_done, 1'b0);
    cyc(30);
    chk1(oscillator_init_done, 1'b1);
    r8(8'h0c, 32'h03, 2'h0);
    w8(8'h00, 8'h04);
    cyc(3);
    chk1(oscillator_init_done, 1'b0);
    $display("test oscillator done");
    wr(8'h00, 8'hff, 4'he, wresp);
    chk({30'h0, wresp}, 32'h0);
    r8(8'h00, 32'h04, 2'h0);
    wr(8'h10, 8'hff, 4'hf, wresp);
    chk({30'h0, wresp}, 32'h2);
    r8(8'h10, 32'h0, 2'h2);
    $display("test refusals done");
    test_done();
  end
endmodule
